// ---- design/uart_misc_cfg_pkg.sv ----
// Constants and types shared by the miscellaneous serial configuration bank
`default_nettype none
package uart_misc_cfg_pkg;

  // Index values held in the configuration index register
  localparam logic [7:0] IDX_RSV_A = 8'h03;
  localparam logic [7:0] IDX_MISC = 8'h04;
  localparam logic [7:0] IDX_RSV_B = 8'h05;
  localparam logic [7:0] IDX_RSV_C = 8'h06;
  localparam logic [7:0] IDX_AUTOPM = 8'h07;
  localparam logic [7:0] IDX_RSV_D = 8'h08;
  localparam logic [7:0] IDX_TEST = 8'h09;

  // Power-on values
  localparam logic [7:0] RST_RSV_A = 8'h70;
  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [7:0] RST_RSV_B = 8'h00;
  localparam logic [7:0] RST_RSV_C = 8'hFF;
  localparam logic [7:0] RST_AUTOPM = 8'h00;
  localparam logic [7:0] RST_RSV_D = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // Field positions in the serial misc clock select register
  localparam int MISC_PORT1_BIT = 4;
  localparam int MISC_PORT2_BIT = 5;
  localparam int MISC_RO_ZERO_BIT = 7;

  // Field positions in the auto power management register
  localparam int APM_UART3_BIT = 2;
  localparam int APM_UART4_BIT = 3;
  localparam int APM_UART2_BIT = 5;
  localparam int APM_UART1_BIT = 6;
  localparam int APM_HW_LO = 2;
  localparam int APM_HW_HI = 7;
  localparam int APM_KEEP_HI = 1;

  // Music rate: 16x sample ticks for 31.25 kbaud from the core clock
  localparam int CLK_HZ = 25_000_000;
  localparam int MUSIC_BAUD = 31_250;
  localparam int OVERSAMPLE = 16;
  localparam int MUSIC_DIV = (CLK_HZ + (MUSIC_BAUD * OVERSAMPLE) / 2) /
                             (MUSIC_BAUD * OVERSAMPLE);
  localparam logic [5:0] MUSIC_DIV_LAST = 6'(MUSIC_DIV - 1);
  localparam logic [5:0] MUSIC_CNT_ZERO = 6'h00;
  localparam logic [5:0] MUSIC_CNT_ONE = 6'h01;

  // One configuration port cycle from the host side decoder
  typedef struct packed {
    logic cfg_state;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] data;
  } cfg_req_t;

  // Auto powerdown enables, one per serial port
  typedef struct packed {
    logic uart1;
    logic uart2;
    logic uart3;
    logic uart4;
  } autopd_t;

endpackage

`default_nettype wire

// ---- design/music_rate_gen.sv ----
// Free-running 16x sample tick generator for the music serial rate
`timescale 1ns/1ps
`default_nettype none

module music_rate_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Sample tick, one cycle wide
  output logic tick_r
);

  // Divider count; the division is exact at 25 MHz so the rate error is zero
  logic [5:0] cnt_r;

  // Divider counter wraps at the last count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= uart_misc_cfg_pkg::MUSIC_CNT_ZERO;
    end else if (cnt_r == uart_misc_cfg_pkg::MUSIC_DIV_LAST) begin
      cnt_r <= uart_misc_cfg_pkg::MUSIC_CNT_ZERO;
    end else begin
      cnt_r <= cnt_r + uart_misc_cfg_pkg::MUSIC_CNT_ONE;
    end
  end

  // Tick is registered so it leaves the module from a flop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= (cnt_r == uart_misc_cfg_pkg::MUSIC_DIV_LAST);
    end
  end

endmodule

`default_nettype wire

// ---- design/uart_misc_config_regs.sv ----
// Indexed configuration registers 03h to 09h of the quad serial device
`timescale 1ns/1ps
`default_nettype none

module uart_misc_config_regs (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hard_reset,
  // Configuration port cycle, same clock domain
  input wire uart_misc_cfg_pkg::cfg_req_t req,
  input wire logic lock_clear,
  // Read answer
  output logic [7:0] rd_data_r,
  output logic rd_ack_r,
  // Lock state
  output logic config_access_lock,
  // Clock selects and sample ticks to the serial ports
  output logic port1_music_clock_sel,
  output logic port2_music_clock_sel,
  input wire logic port1_std_tick,
  input wire logic port2_std_tick,
  output logic port1_rate_tick_r,
  output logic port2_rate_tick_r,
  // Auto powerdown enables and test bits
  output uart_misc_cfg_pkg::autopd_t autopd_en,
  output logic [7:0] test_bits
);

  // Register storage
  logic [7:0] misc_r; // Serial misc clock select
  logic [7:0] autopm_r; // Auto power management
  logic [7:0] test_r; // Test control four
  logic lock_r; // High while configuration access is allowed
  logic music_tick; // 16x tick at the music rate

  // True when a cycle may touch the given index
  function automatic logic hit(input uart_misc_cfg_pkg::cfg_req_t r,
                               input logic [7:0] idx,
                               input logic lk);
    hit = r.cfg_state && lk && (r.idx == idx);
  endfunction

  // Read value for an index; unknown indices return zero
  function automatic logic [7:0] read_mux(input logic [7:0] idx,
                                          input logic [7:0] misc,
                                          input logic [7:0] apm,
                                          input logic [7:0] tst);
    unique case (idx)
      uart_misc_cfg_pkg::IDX_RSV_A: read_mux = uart_misc_cfg_pkg::RST_RSV_A;
      uart_misc_cfg_pkg::IDX_MISC: read_mux = misc;
      uart_misc_cfg_pkg::IDX_RSV_B: read_mux = uart_misc_cfg_pkg::RST_RSV_B;
      uart_misc_cfg_pkg::IDX_RSV_C: read_mux = uart_misc_cfg_pkg::RST_RSV_C;
      uart_misc_cfg_pkg::IDX_AUTOPM: read_mux = apm;
      uart_misc_cfg_pkg::IDX_RSV_D: read_mux = uart_misc_cfg_pkg::RST_RSV_D;
      uart_misc_cfg_pkg::IDX_TEST: read_mux = tst;
      default: read_mux = uart_misc_cfg_pkg::DATA_ZERO;
    endcase
  endfunction

  // True when the index belongs to this bank
  function automatic logic ours(input logic [7:0] idx);
    ours = (idx >= uart_misc_cfg_pkg::IDX_RSV_A) &&
           (idx <= uart_misc_cfg_pkg::IDX_TEST);
  endfunction

  // Write strobes per stored register
  logic wr_misc;
  logic wr_apm;
  logic wr_test;
  logic rd_hit;
  assign wr_misc = req.wr && hit(req, uart_misc_cfg_pkg::IDX_MISC, lock_r);
  assign wr_apm = req.wr && hit(req, uart_misc_cfg_pkg::IDX_AUTOPM, lock_r);
  assign wr_test = req.wr && hit(req, uart_misc_cfg_pkg::IDX_TEST, lock_r);
  assign rd_hit = req.rd && req.cfg_state && lock_r && ours(req.idx);

  // Lock: once cleared, only a power-on or hard reset sets it again
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_r <= 1'b1;
    end else if (hard_reset) begin
      lock_r <= 1'b1;
    end else if (lock_clear) begin
      lock_r <= 1'b0;
    end
  end

  // Misc clock select: power-on only; bit 7 always reads zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      misc_r <= uart_misc_cfg_pkg::RST_MISC;
    end else if (wr_misc) begin
      misc_r <= req.data;
      misc_r[uart_misc_cfg_pkg::MISC_RO_ZERO_BIT] <= 1'b0;
    end
  end

  // Auto power management: hard reset spares the low two bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      autopm_r <= uart_misc_cfg_pkg::RST_AUTOPM;
    end else if (hard_reset) begin
      autopm_r[uart_misc_cfg_pkg::APM_HW_HI:uart_misc_cfg_pkg::APM_HW_LO] <=
        uart_misc_cfg_pkg::RST_AUTOPM[uart_misc_cfg_pkg::APM_HW_HI:
                                      uart_misc_cfg_pkg::APM_HW_LO];
    end else if (wr_apm) begin
      autopm_r <= req.data;
    end
  end

  // Test register is stored but drives nothing inside this bank
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      test_r <= uart_misc_cfg_pkg::RST_TEST;
    end else if (wr_test) begin
      test_r <= req.data;
    end
  end

  // Read answer, one cycle after the strobe; data held until next read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= uart_misc_cfg_pkg::DATA_ZERO;
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= rd_hit;
      if (rd_hit) begin
        rd_data_r <= read_mux(req.idx, misc_r, autopm_r,
                              test_r);
      end
    end
  end

  // Register bits go straight out as levels
  assign config_access_lock = lock_r;
  assign port1_music_clock_sel = misc_r[uart_misc_cfg_pkg::MISC_PORT1_BIT];
  assign port2_music_clock_sel = misc_r[uart_misc_cfg_pkg::MISC_PORT2_BIT];
  assign autopd_en.uart1 = autopm_r[uart_misc_cfg_pkg::APM_UART1_BIT];
  assign autopd_en.uart2 = autopm_r[uart_misc_cfg_pkg::APM_UART2_BIT];
  assign autopd_en.uart3 = autopm_r[uart_misc_cfg_pkg::APM_UART3_BIT];
  assign autopd_en.uart4 =
    autopm_r[uart_misc_cfg_pkg::APM_UART4_BIT];
  assign test_bits = test_r;

  // Music rate source shared by both ports
  music_rate_gen u_music (
    .core_clk(core_clk),
    .rst(rst),
    .tick_r(music_tick)
  );

  // Per-port sample tick select; a switch mid-character garbles that char
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port1_rate_tick_r <= 1'b0;
      port2_rate_tick_r <= 1'b0;
    end else begin
      port1_rate_tick_r <= port1_music_clock_sel ? music_tick
                                                 : port1_std_tick;
      port2_rate_tick_r <= port2_music_clock_sel ? music_tick
                                                 : port2_std_tick;
    end
  end

  // Helper: cycles since the last music tick, for the rate check
  logic [5:0] gap_r;
  logic gap_seen_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_r <= uart_misc_cfg_pkg::MUSIC_CNT_ZERO;
      gap_seen_r <= 1'b0;
    end else if (music_tick) begin
      gap_r <= uart_misc_cfg_pkg::MUSIC_CNT_ZERO;
      gap_seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + uart_misc_cfg_pkg::MUSIC_CNT_ONE;
    end
  end

  // Read of index 03 returns its fixed value
  property p_rsv_a_read;
    @(posedge core_clk) disable iff (rst)
      rd_ack_r && ($past(req.idx) == uart_misc_cfg_pkg::IDX_RSV_A)
      |-> rd_data_r == uart_misc_cfg_pkg::RST_RSV_A;
  endproperty
  a_rsv_a_read: assert property (p_rsv_a_read)
    else $error("index 03 read wrong value");

  // Read of index 05 returns zero
  property p_rsv_b_read;
    @(posedge core_clk) disable iff (rst)
      rd_ack_r && ($past(req.idx) == uart_misc_cfg_pkg::IDX_RSV_B)
      |-> rd_data_r == uart_misc_cfg_pkg::RST_RSV_B;
  endproperty
  a_rsv_b_read: assert property (p_rsv_b_read)
    else $error("index 05 read wrong value");

  // Read of index 06 returns all ones, even after a write to it
  property p_rsv_c_read;
    @(posedge core_clk) disable iff (rst)
      req.rd && req.cfg_state && lock_r &&
      (req.idx == uart_misc_cfg_pkg::IDX_RSV_C)
      |=> rd_ack_r && (rd_data_r == uart_misc_cfg_pkg::RST_RSV_C);
  endproperty
  a_rsv_c_read: assert property (p_rsv_c_read)
    else $error("index 06 read wrong value");

  // Read of index 08 returns zero
  property p_rsv_d_read;
    @(posedge core_clk) disable iff (rst)
      rd_ack_r && ($past(req.idx) == uart_misc_cfg_pkg::IDX_RSV_D)
      |-> rd_data_r == uart_misc_cfg_pkg::RST_RSV_D;
  endproperty
  a_rsv_d_read: assert property (p_rsv_d_read)
    else $error("index 08 read wrong value");

  // Writes outside the configuration state leave the misc register alone
  property p_misc_gate;
    @(posedge core_clk) disable iff (rst)
      req.wr && !req.cfg_state |=> $stable(misc_r);
  endproperty
  a_misc_gate: assert property (p_misc_gate)
    else $error("misc register written outside config state");

  // Accepted misc write reaches both clock select outputs next cycle
  property p_misc_sel;
    @(posedge core_clk) disable iff (rst)
      wr_misc |=>
      (port1_music_clock_sel == $past(req.data[4])) &&
      (port2_music_clock_sel == $past(req.data[5]));
  endproperty
  a_misc_sel: assert property (p_misc_sel)
    else $error("clock select did not follow write");

  // Music ticks come exactly one divider period apart
  property p_music_rate;
    @(posedge core_clk) disable iff (rst)
      music_tick && gap_seen_r |-> gap_r == uart_misc_cfg_pkg::MUSIC_DIV_LAST;
  endproperty
  a_music_rate: assert property (p_music_rate)
    else $error("music tick period wrong");

  // With port 1 on music rate its tick follows the music source
  property p_port1_follow;
    @(posedge core_clk) disable iff (rst)
      port1_music_clock_sel && music_tick ##1 port1_music_clock_sel
      |-> port1_rate_tick_r;
  endproperty
  a_port1_follow: assert property (p_port1_follow)
    else $error("port 1 tick not from music source");

  // With port 2 on music rate its tick is the music tick a cycle late
  property p_port2_follow;
    @(posedge core_clk) disable iff (rst)
      port2_music_clock_sel |=> port2_rate_tick_r == $past(music_tick);
  endproperty
  a_port2_follow: assert property (p_port2_follow)
    else $error("port 2 tick not from music source");

  // With the music rate off, port 1 passes its standard tick a cycle late
  property p_port1_std;
    @(posedge core_clk) disable iff (rst)
      !port1_music_clock_sel |=> port1_rate_tick_r == $past(port1_std_tick);
  endproperty
  a_port1_std: assert property (p_port1_std)
    else $error("port 1 standard tick not passed");

  // A read that is not allowed gets no answer and leaves the data alone,
  // so software polling a locked bank sees stale data, never garbage
  property p_rd_refused;
    @(posedge core_clk) disable iff (rst)
      !(req.rd && req.cfg_state && lock_r) |=>
      !rd_ack_r && $stable(rd_data_r);
  endproperty
  a_rd_refused: assert property (p_rd_refused)
    else $error("refused read answered or changed read data");

  // Power management writes outside config state are dropped
  property p_apm_gate;
    @(posedge core_clk) disable iff (rst)
      req.wr && !req.cfg_state && !hard_reset |=> $stable(autopm_r);
  endproperty
  a_apm_gate: assert property (p_apm_gate)
    else $error("power register written outside config state");

  // Accepted power write drives all four enables next cycle
  property p_apm_bits;
    @(posedge core_clk) disable iff (rst)
      wr_apm && !hard_reset |=>
      (autopd_en == {$past(req.data[6]), $past(req.data[5]),
                     $past(req.data[2]), $past(req.data[3])});
  endproperty
  a_apm_bits: assert property (p_apm_bits)
    else $error("powerdown enables do not match write");

  // Hard reset clears the upper six bits and keeps the lower two
  property p_apm_hard;
    @(posedge core_clk) disable iff (rst)
      hard_reset |=>
      (autopm_r[7:2] == 6'h00) && (autopm_r[1:0] == $past(autopm_r[1:0]));
  endproperty
  a_apm_hard: assert property (p_apm_hard)
    else $error("hard reset handled power register wrongly");

  // Test register takes an accepted write, otherwise holds
  property p_test_wr;
    @(posedge core_clk) disable iff (rst)
      req.wr && (req.idx == uart_misc_cfg_pkg::IDX_TEST)
      |=> test_r == ($past(wr_test) ? $past(req.data) : $past(test_r));
  endproperty
  a_test_wr: assert property (p_test_wr)
    else $error("test register write gating wrong");

  // Cleared lock freezes every register and stays clear without reset
  property p_lock_block;
    @(posedge core_clk) disable iff (rst)
      !lock_r && !hard_reset |=>
      !lock_r && $stable(misc_r) && $stable(autopm_r) && $stable(test_r)
      && !rd_ack_r;
  endproperty
  a_lock_block: assert property (p_lock_block)
    else $error("access passed while lock cleared");

  // Main scenarios
  c_music_on: cover property (@(posedge core_clk) disable iff (rst)
    wr_misc && req.data[4] ##1 port1_music_clock_sel);
  c_hard_reset: cover property (@(posedge core_clk) disable iff (rst)
    autopm_r[1] ##1 hard_reset ##1 autopm_r[1]);
  c_locked_wr: cover property (@(posedge core_clk) disable iff (rst)
    !lock_r && req.wr && req.cfg_state);
  c_apm_on: cover property (@(posedge core_clk) disable iff (rst)
    wr_apm ##1 autopd_en.uart1);

endmodule

`default_nettype wire

// ---- test/host_cfg_model.sv ----
// Host software model driving configuration port cycles into the bank
`timescale 1ns/1ps
`default_nettype none

module host_cfg_model (
  // Clock
  input wire logic core_clk,
  // Answer from the bank
  input wire logic [7:0] rd_data_r,
  input wire logic rd_ack_r,
  // Cycle and lock request toward the bank
  output uart_misc_cfg_pkg::cfg_req_t req,
  output logic lock_clear
);
  // Idle port at time zero
  initial begin
    req = '0;
    lock_clear = 1'b0;
  end

  // One write or read, launched after a falling edge, answer taken a
  // cycle later; the index stays put, as the index register would
  task automatic cfg_cycle(input logic is_wr, input logic cs,
                           input logic [7:0] idx, input logic [7:0] d,
                           output logic ack, output logic [7:0] q);
    @(negedge core_clk);
    req.cfg_state = cs;
    req.wr = is_wr;
    req.rd = !is_wr;
    req.idx = idx;
    // Test register is only ever written with its power-on value
    req.data = (idx == 8'h09) ? 8'h00 : d;
    @(negedge core_clk);
    ack = rd_ack_r;
    q = rd_data_r;
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask

  // Software clearing the lock bit, one cycle pulse
  task automatic drop_lock();
    @(negedge core_clk);
    lock_clear = 1'b1;
    @(negedge core_clk);
    lock_clear = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the miscellaneous serial configuration bank
`timescale 1ns/1ps
`default_nettype none

`define CHECK_EQ(nm, ex, got) \
  begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, ex, got); end end

module tb;
  logic core_clk, rst, hard_reset, lock_clear, std1, std2;
  uart_misc_cfg_pkg::cfg_req_t req;
  logic [7:0] rd_data_r, test_bits;
  logic rd_ack_r, lock, sel1, sel2, tk1, tk2;
  uart_misc_cfg_pkg::autopd_t autopd;
  int errors, cmp_count, cyc;
  logic [31:0] rng;
  // Expected register image kept by the bench
  logic [7:0] misc_m, apm_m, test_m;
  logic lock_m;
  // Music tick spacing in core cycles, from clock and 16x oversampling
  localparam int MDIV = 25_000_000 / (31_250 * 16);

  uart_misc_config_regs dut (.core_clk(core_clk), .rst(rst),
    .hard_reset(hard_reset), .req(req), .lock_clear(lock_clear),
    .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r),
    .config_access_lock(lock), .port1_music_clock_sel(sel1),
    .port2_music_clock_sel(sel2), .port1_std_tick(std1),
    .port2_std_tick(std2), .port1_rate_tick_r(tk1),
    .port2_rate_tick_r(tk2), .autopd_en(autopd), .test_bits(test_bits));

  host_cfg_model host (.core_clk(core_clk), .rd_data_r(rd_data_r),
    .rd_ack_r(rd_ack_r), .req(req), .lock_clear(lock_clear));

  // 25 MHz core clock
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // Repeatable random source
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Value a read of an index should return
  function automatic logic [7:0] exp_val(input logic [7:0] idx);
    case (idx)
      8'h03: return 8'h70;
      8'h04: return misc_m;
      8'h06: return 8'hFF;
      8'h07: return apm_m;
      8'h09: return test_m;
      default: return 8'h00;
    endcase
  endfunction

  function automatic void model_por();
    misc_m = 8'h00;
    apm_m = 8'h00;
    test_m = 8'h00;
    lock_m = 1'b1;
  endfunction

  // Level outputs against the register image
  task automatic check_outs();
    `CHECK_EQ("sel1", misc_m[4], sel1)
    `CHECK_EQ("sel2", misc_m[5], sel2)
    `CHECK_EQ("apd3", apm_m[2], autopd.uart3)
    `CHECK_EQ("apd4", apm_m[3], autopd.uart4)
    `CHECK_EQ("apd2", apm_m[5], autopd.uart2)
    `CHECK_EQ("apd1", apm_m[6], autopd.uart1)
    `CHECK_EQ("test", test_m, test_bits)
    `CHECK_EQ("lock", lock_m, lock)
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic cs);
    logic a;
    logic [7:0] q;
    host.cfg_cycle(1'b1, cs, idx, d, a, q);
    if (cs && lock_m) begin
      if (idx == 8'h04) misc_m = d & 8'h7F;
      if (idx == 8'h07) apm_m = d;
    end
    check_outs();
  endtask

  task automatic rd(input logic [7:0] idx, input logic cs);
    logic a, ea;
    logic [7:0] q;
    host.cfg_cycle(1'b0, cs, idx, 8'h00, a, q);
    ea = cs && lock_m && idx >= 8'h03 && idx <= 8'h09;
    `CHECK_EQ("ack", ea, a)
    if (ea) `CHECK_EQ("rdata", exp_val(idx), q)
  endtask

  task automatic hw_reset();
    @(negedge core_clk);
    hard_reset = 1'b1;
    @(negedge core_clk);
    hard_reset = 1'b0;
    apm_m = apm_m & 8'h03;
    lock_m = 1'b1;
    check_outs();
  endtask

  // Cycles between two selected ticks of one port
  task automatic gap(input logic p);
    int n;
    for (n = 0; n < 200 && !(p ? tk2 : tk1); n++) @(negedge core_clk);
    @(negedge core_clk);
    for (n = 1; n < 200 && !(p ? tk2 : tk1); n++) @(negedge core_clk);
    `CHECK_EQ("gap", MDIV, n)
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0] i;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    rng = 32'h0000001A;
    rst = 1'b1;
    hard_reset = 1'b0;
    std1 = 1'b0;
    std2 = 1'b0;
    model_por();
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    check_outs();
    // Power-on values of every index
    for (i = 8'h02; i <= 8'h0A; i++) rd(i, 1'b1);
    wr(8'h04, 8'hFF, 1'b1);
    wr(8'h07, 8'hFF, 1'b1);
    wr(8'h03, 8'h00, 1'b1);
    rd(8'h03, 1'b1);
    wr(8'h06, 8'h00, 1'b1);
    rd(8'h06, 1'b1);
    hw_reset();
    rd(8'h07, 1'b1);
    // Outside the configuration state nothing moves
    wr(8'h04, 8'h00, 1'b0);
    wr(8'h07, 8'h00, 1'b0);
    rd(8'h04, 1'b0);
    // Cleared lock blocks both directions until hard reset
    host.drop_lock();
    lock_m = 1'b0;
    wr(8'h04, 8'h00, 1'b1);
    rd(8'h07, 1'b1);
    hw_reset();
    rd(8'h04, 1'b1);
    wr(8'h04, 8'h30, 1'b1);
    gap(1'b0);
    gap(1'b1);
    wr(8'h04, 8'h00, 1'b1);
    // Standard ticks pass one cycle late when the music rate is off
    repeat (30) begin
      r = xs();
      std1 = r[0];
      std2 = r[1];
      @(negedge core_clk);
      `CHECK_EQ("tk1", r[0], tk1)
      `CHECK_EQ("tk2", r[1], tk2)
    end
    std1 = 1'b0;
    std2 = 1'b0;
    // Random mix of cycles over indices 00h to 0Fh
    repeat (80) begin
      r = xs();
      if (r[6]) wr({4'h0, r[3:0]}, r[15:8], r[4] | r[5]);
      else rd({4'h0, r[3:0]}, r[4] | r[5]);
    end
    // Power-on reset in mid-run returns everything to its power-on value
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    model_por();
    check_outs();
    rd(8'h04, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
